// ### verilog/cbt_pkg.sv
`default_nettype none
package cbt_pkg;
    // Cycle kinds decoded from command select and write-not-read
    typedef enum logic [1:0] {
        CBT_KIND_CSR_RD,
        CBT_KIND_OPCODE_WR,
        CBT_KIND_DATA_RD,
        CBT_KIND_DATA_WR
    } cbt_kind_t;
    typedef enum logic [1:0] {
        CBT_IDLE,
        CBT_READY_SENS,
        CBT_PIPELINE
    } cbt_bus_state_t;
    localparam int CBT_DATA_W = 32;
    // Error spacing in host double-rate periods
    localparam int CBT_ERR_GAP_DBL = 6;
    // Bus clock is half the double-rate clock
    localparam int CBT_ERR_GAP_CYC = (CBT_ERR_GAP_DBL + 1) / 2;
    localparam int CBT_GAP_W = 3;
    localparam logic [CBT_GAP_W-1:0] CBT_GAP_MAX = CBT_GAP_W'(CBT_ERR_GAP_CYC);
    // Ready-sensitive count at which ready is driven
    localparam logic [1:0] CBT_RS_FIRST = 2'h1;
    localparam logic [1:0] CBT_RS_SECOND = 2'h2;
endpackage
`default_nettype wire

// ### verilog/cbt_clk_phase.sv
`timescale 1ns/1ps
`default_nettype none
module cbt_clk_phase (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    output logic bus_phase_o
);
    typedef struct packed {
        logic phase;
    } cbt_phase_reg_t;
    cbt_phase_reg_t r;
    cbt_phase_reg_t next_r;
    // ----------------------------------------
    // Divide by two
    // ----------------------------------------
    always_comb begin
        next_r = r;
        // [RULE1] Halve double rate
        if (ce_i) begin
            next_r.phase = ~r.phase;
        end
        // [RULE25] Reset aligns phase
        if (!rst_b_i) begin
            next_r.phase = 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        r <= next_r;
    end
    assign bus_phase_o = r.phase;
endmodule // cbt_clk_phase
`default_nettype wire

// ### verilog/cbt_bus_tracker.sv
// Functional notes
// [RULE1] Bus clock is double clock halved
// [RULE2] Select needs enable, both selects, strobe
// [RULE3] Host never signals half width here
// [RULE4] Sample direction and command at strobe
// [RULE5] Strobe with nothing pending: nonpipelined
// [RULE6] Accept pipelined strobe from second clock
// [RULE7] Idle after reset and cycle ends
// [RULE8] Wait in ready-sensitive until ready
// [RULE9] Plain writes: ready in first state
// [RULE10] Reads, env/restore writes: second state
// [RULE11] Ready output lasts one clock
// [RULE12] Read data driven during ready-sensitive
// [RULE13] Reads need one wait state
// [RULE14] External ready must add wait states
// [RULE15] Release data bus leaving ready-sensitive
// [RULE16] Strobe plus ready goes to pipeline
// [RULE17] Pipeline entry also releases data
// [RULE18] Pipeline lasts one clock, back
// [RULE19] Zero-wait write leads nonpipelined cycle
// [RULE20] Busy spans execution, requests inside
// [RULE21] Error six double periods from edges
// [RULE22] Command and direction decode cycle kind
// [RULE23] Enable low floats all outputs
// [RULE24] Ready only on own cycles
// [RULE25] Reset aligns bus clock phase
`timescale 1ns/1ps
`default_nettype none
module cbt_bus_tracker #(
    parameter int DATA_W = cbt_pkg::CBT_DATA_W
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic address_strobe_n_i,
    input wire logic ready_n_i,
    input wire logic status_enable_i,
    input wire logic coproc_select_one_n_i,
    input wire logic coproc_select_two_i,
    input wire logic command_select_n_i,
    input wire logic write_not_read_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic [DATA_W-1:0] read_data_i,
    input wire logic env_restore_op_i,
    input wire logic exec_start_i,
    input wire logic exec_done_i,
    input wire logic operand_want_i,
    input wire logic error_event_i,
    output logic ready_out_n_o,
    output logic ready_out_oe_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic busy_n_o,
    output logic busy_oe_o,
    output logic operand_request_o,
    output logic operand_request_oe_o,
    output logic error_n_o,
    output logic error_oe_o,
    output logic wr_strobe_o,
    output logic [1:0] wr_kind_o,
    output logic [DATA_W-1:0] wr_data_o,
    output logic rd_strobe_o,
    output logic bus_phase_o
);
    typedef struct packed {
        cbt_pkg::cbt_bus_state_t state;
        cbt_pkg::cbt_kind_t kind;
        logic slow;
        logic foreign;
        logic [1:0] rs_count;
        cbt_pkg::cbt_kind_t wkind;
        logic ready_out;
        logic drive_data;
        logic [DATA_W-1:0] dout;
        logic wr_stb;
        logic [DATA_W-1:0] wdata;
        logic rd_stb;
        logic busy;
        logic req;
        logic err;
        logic [cbt_pkg::CBT_GAP_W-1:0] since_req;
        logic err_pending;
        logic done_pending;
        logic [cbt_pkg::CBT_GAP_W-1:0] since_err;
    } cbt_state_t;
    cbt_state_t r;
    cbt_state_t next_r;
    logic selected;
    logic strobe;
    logic bus_phase;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic cbt_pkg::cbt_kind_t decode_kind(input logic cmd_n, input logic wr);
        // [RULE22] Kind decode
        case ({cmd_n, wr})
            2'h0: decode_kind = cbt_pkg::CBT_KIND_CSR_RD;
            2'h1: decode_kind = cbt_pkg::CBT_KIND_OPCODE_WR;
            2'h2: decode_kind = cbt_pkg::CBT_KIND_DATA_RD;
            default: decode_kind = cbt_pkg::CBT_KIND_DATA_WR;
        endcase
    endfunction

    function automatic logic kind_is_read(input cbt_pkg::cbt_kind_t k);
        kind_is_read = (k == cbt_pkg::CBT_KIND_CSR_RD) || (k == cbt_pkg::CBT_KIND_DATA_RD);
    endfunction

    cbt_clk_phase u_phase (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .bus_phase_o(bus_phase)
    );

    // [RULE2] Own cycle qualification
    assign strobe = !address_strobe_n_i;
    assign selected = strobe && status_enable_i && !coproc_select_one_n_i && coproc_select_two_i;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic start;
        logic rs_next_is_one;
        start = 1'b0;
        rs_next_is_one = 1'b0;
        next_r = r;
        next_r.wr_stb = 1'b0;
        next_r.rd_stb = 1'b0;
        case (r.state)
            cbt_pkg::CBT_IDLE: begin
                // [RULE5] Nonpipelined start
                if (selected) begin
                    start = 1'b1;
                    next_r.state = cbt_pkg::CBT_READY_SENS;
                end
            end
            cbt_pkg::CBT_READY_SENS: begin
                // [RULE8] Wait for ready
                if (!ready_n_i) begin
                    // [RULE16] Pipelined strobe
                    if (strobe) begin
                        next_r.state = cbt_pkg::CBT_PIPELINE;
                    end else begin
                        // [RULE7] Back to idle
                        // [RULE19] Zero-wait write ends first
                        next_r.state = cbt_pkg::CBT_IDLE;
                    end
                    // [RULE15] Release on exit
                    // [RULE17] Same on pipeline entry
                    next_r.drive_data = 1'b0;
                    next_r.ready_out = 1'b0;
                    if (!kind_is_read(r.kind)) begin
                        next_r.wr_stb = 1'b1;
                        next_r.wdata = data_i;
                        // Kind kept apart: a pipelined strobe reloads kind
                        next_r.wkind = r.kind;
                    end
                end else if (r.rs_count != 2'h3) begin
                    // Saturates so long waits never repeat the ready pulse
                    next_r.rs_count = r.rs_count + 2'h1;
                end
            end
            cbt_pkg::CBT_PIPELINE: begin
                // [RULE18] One clock then back
                next_r.state = cbt_pkg::CBT_READY_SENS;
                rs_next_is_one = 1'b1;
            end
            default: begin
                next_r.state = cbt_pkg::CBT_IDLE;
            end
        endcase
        // [RULE6] Pipelined cycle captured at strobe
        if (r.state == cbt_pkg::CBT_READY_SENS && !ready_n_i && selected) begin
            start = 1'b1;
        end else if (r.state == cbt_pkg::CBT_READY_SENS && !ready_n_i && strobe) begin
            // Foreign cycle rides pipeline states but stays silent
            next_r.kind = cbt_pkg::CBT_KIND_CSR_RD;
            next_r.slow = 1'b1;
            next_r.foreign = 1'b1;
            next_r.rs_count = 2'h3;
        end
        if (start) begin
            // [RULE4] Sample at strobe
            next_r.kind = decode_kind(command_select_n_i, write_not_read_i);
            // [RULE10] Slow kinds
            next_r.slow = kind_is_read(decode_kind(command_select_n_i, write_not_read_i))
                || env_restore_op_i;
            next_r.rs_count = 2'h0;
            next_r.foreign = 1'b0;
        end
        if (r.state == cbt_pkg::CBT_IDLE && selected) begin
            next_r.rs_count = cbt_pkg::CBT_RS_FIRST;
        end
        if (rs_next_is_one && r.rs_count == 2'h0) begin
            next_r.rs_count = cbt_pkg::CBT_RS_FIRST;
        end
        // [RULE9] [RULE11] One-clock ready pulse
        // [RULE24] Only own cycles
        next_r.ready_out = (next_r.state == cbt_pkg::CBT_READY_SENS)
            && (next_r.rs_count == (next_r.slow ? cbt_pkg::CBT_RS_SECOND : cbt_pkg::CBT_RS_FIRST));
        // [RULE12] Drive read data
        // [RULE13] Data valid before ready
        if (next_r.state == cbt_pkg::CBT_READY_SENS && kind_is_read(next_r.kind)
            && !next_r.foreign) begin
            next_r.drive_data = 1'b1;
            if (!r.drive_data) begin
                next_r.dout = read_data_i;
                next_r.rd_stb = 1'b1;
            end
        end else begin
            next_r.drive_data = 1'b0;
        end
        // ----------------------------------------
        // Execution handshakes
        // ----------------------------------------
        // [RULE20] Busy interval
        if (exec_start_i) begin
            next_r.busy = 1'b1;
        end
        // Done is a pulse; remember it while the error gap runs
        if (exec_done_i && r.busy) begin
            next_r.done_pending = 1'b1;
        end
        // [RULE21] Error spacing after request
        if (r.req) begin
            next_r.since_req = '0;
        end else if (r.since_req != cbt_pkg::CBT_GAP_MAX) begin
            next_r.since_req = r.since_req + 1'b1;
        end
        if (error_event_i && r.busy) begin
            next_r.err_pending = 1'b1;
        end
        if (r.err_pending && !r.req && r.since_req == cbt_pkg::CBT_GAP_MAX) begin
            next_r.err = 1'b1;
            next_r.err_pending = 1'b0;
        end
        // [RULE21] Error leads busy release by the gap
        if (r.err) begin
            if (r.since_err != cbt_pkg::CBT_GAP_MAX) begin
                next_r.since_err = r.since_err + 1'b1;
            end
        end else begin
            next_r.since_err = '0;
        end
        if (r.done_pending && !r.err_pending
            && (!r.err || r.since_err == cbt_pkg::CBT_GAP_MAX)) begin
            next_r.busy = 1'b0;
            next_r.done_pending = 1'b0;
        end
        // Error held until the next instruction starts
        if (exec_start_i) begin
            next_r.err = 1'b0;
            next_r.done_pending = 1'b0;
        end
        // [RULE20] Request last, so it never outlives busy
        next_r.req = next_r.busy && operand_want_i;
        if (!ce_i) begin
            next_r = r;
        end
        if (!rst_b_i) begin
            next_r = '0;
            next_r.state = cbt_pkg::CBT_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        r <= next_r;
    end

    // ----------------------------------------
    // Pin outputs
    // ----------------------------------------
    // [RULE23] Enable low floats outputs
    assign ready_out_n_o = !r.ready_out;
    assign ready_out_oe_o = status_enable_i;
    assign data_o = r.dout;
    assign data_oe_o = status_enable_i && r.drive_data;
    assign busy_n_o = !r.busy;
    assign busy_oe_o = status_enable_i;
    assign operand_request_o = r.req;
    assign operand_request_oe_o = status_enable_i;
    assign error_n_o = !r.err;
    assign error_oe_o = status_enable_i;
    assign wr_strobe_o = r.wr_stb;
    assign wr_kind_o = r.wkind;
    assign wr_data_o = r.wdata;
    assign rd_strobe_o = r.rd_stb;
    assign bus_phase_o = bus_phase;
endmodule // cbt_bus_tracker
`default_nettype wire

// ### tb/cbt_bus_tracker_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cbt_checker (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic address_strobe_n_i,
    input wire logic ready_n_i,
    input wire logic status_enable_i,
    input wire logic coproc_select_one_n_i,
    input wire logic coproc_select_two_i,
    input wire logic write_not_read_i,
    input wire logic env_restore_op_i,
    input wire logic ready_out_n_o,
    input wire logic data_oe_o,
    input wire logic busy_n_o,
    input wire logic operand_request_o,
    input wire logic error_n_o
);
    // ----------------
    // Ownership shadow
    // ----------------
    logic own;
    logic act;
    logic fast;
    assign own = status_enable_i && !coproc_select_one_n_i && coproc_select_two_i
        && !address_strobe_n_i;
    assign fast = write_not_read_i && !env_restore_op_i;
    // Assumes clock enable held high
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            act <= 1'b0;
        end else if (own || !ready_n_i) begin
            act <= own;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_start;
        own && !act;
    endsequence
    sequence s_pipe;
        own && act && !ready_n_i;
    endsequence
    sequence s_late;
        ready_out_n_o ##1 !ready_out_n_o;
    endsequence
    a_fast_write: assert property (s_start ##0 fast |=> !ready_out_n_o)
        else $error("write ready late");
    a_slow_ready: assert property (s_start ##0 !fast |=> s_late)
        else $error("slow ready wrong");
    a_read_drive: assert property (s_start ##0 !write_not_read_i |=> data_oe_o)
        else $error("read data not driven");
    a_ready_pulse: assert property ($fell(ready_out_n_o) |=> ready_out_n_o)
        else $error("ready too long");
    a_data_release: assert property (data_oe_o && !ready_n_i |=> !data_oe_o)
        else $error("data bus kept");
    a_pipe_write: assert property (s_pipe ##0 fast |=> s_late)
        else $error("pipelined ready wrong");
    a_request_busy: assert property (operand_request_o |-> !busy_n_o)
        else $error("request outside busy");
    a_error_gap: assert property ($fell(operand_request_o) |-> error_n_o [*3])
        else $error("error too soon");
    a_busy_gap: assert property ($fell(error_n_o) |-> !busy_n_o [*3])
        else $error("busy released too soon after error");
endmodule // cbt_checker
bind cbt_bus_tracker cbt_checker u_chk (
    .clk_i, .rst_b_i, .address_strobe_n_i, .ready_n_i, .status_enable_i,
    .coproc_select_one_n_i, .coproc_select_two_i, .write_not_read_i, .env_restore_op_i,
    .ready_out_n_o, .data_oe_o, .busy_n_o, .operand_request_o, .error_n_o
);
`default_nettype wire

// ### tb/cbt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbt_host_model (
    input wire logic clk_i,
    input wire logic ro_n_i,
    input wire logic [cbt_pkg::CBT_DATA_W-1:0] rdd_i,
    input wire logic [cbt_pkg::CBT_DATA_W-1:0] wrd_i,
    output logic ads_n_o,
    output logic rdy_n_o,
    output logic en_o,
    output logic s1_n_o,
    output logic s2_o,
    output logic cmd_n_o,
    output logic wnr_o,
    output logic env_o,
    output logic [cbt_pkg::CBT_DATA_W-1:0] wd_o
);
    // ----------
    // Host cycles
    // ----------
    bit pend = 1'b0;
    bit own = 1'b1;
    int rdy_cnt = 0;
    initial begin
        {ads_n_o, rdy_n_o, en_o, s1_n_o, s2_o, cmd_n_o, wnr_o, env_o} = 8'hE0;
        wd_o = 32'h0;
    end
    always @(negedge clk_i) begin
        if (ro_n_i === 1'b0) begin
            rdy_cnt++;
        end
    end
    task automatic cyc(input logic [1:0] k, input logic e, input int waits,
        input logic [31:0] wd, input int nk, output logic [31:0] rd);
        int lat;
        lat = ((k[0] && !e) ? 1 : 2) + waits;
        if (!pend) begin
            @(posedge clk_i);
            ads_n_o <= 1'b0;
            s2_o <= own;
            cmd_n_o <= k[1];
            wnr_o <= k[0];
            env_o <= e;
            wd_o <= wd;
        end
        for (int i = 1; i <= lat; i++) begin
            @(posedge clk_i);
            ads_n_o <= !(i == lat && nk >= 0);
            rdy_n_o <= (i != lat);
        end
        if (nk >= 0) begin
            cmd_n_o <= nk[1];
            wnr_o <= nk[0];
            env_o <= 1'b0;
        end
        @(negedge clk_i);
        rd = rdd_i;
        @(posedge clk_i);
        rdy_n_o <= 1'b1;
        ads_n_o <= 1'b1;
        // Past hold time, so show a changed pattern
        wd_o <= ~wd_o;
        pend = (nk >= 0);
        @(negedge clk_i);
        if (k[0]) begin
            rd = wrd_i;
        end
    endtask
endmodule // cbt_host_model
`default_nettype wire

// ### tb/test_coproc_host_bus_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module test_coproc_host_bus_tracker;
    logic clk_i, rst_b_i, exec_start_i, exec_done_i, operand_want_i, error_event_i;
    logic address_strobe_n_i, ready_n_i, status_enable_i, coproc_select_one_n_i;
    logic coproc_select_two_i, command_select_n_i, write_not_read_i, env_restore_op_i;
    logic [31:0] data_i, read_data_i, data_o, wr_data_o, rd;
    logic ready_out_n_o, ready_out_oe_o, busy_n_o, busy_oe_o, operand_request_o;
    logic error_n_o, wr_strobe_o;
    logic [1:0] wr_kind_o;
    int failures;
    int checked;
    int c0;
    cbt_bus_tracker DUT (
        .clk_i, .rst_b_i, .ce_i(1'b1), .address_strobe_n_i, .ready_n_i, .status_enable_i,
        .coproc_select_one_n_i, .coproc_select_two_i, .command_select_n_i, .write_not_read_i,
        .data_i, .read_data_i, .env_restore_op_i, .exec_start_i, .exec_done_i, .operand_want_i,
        .error_event_i, .ready_out_n_o, .ready_out_oe_o, .data_o, .data_oe_o(), .busy_n_o,
        .busy_oe_o, .operand_request_o, .operand_request_oe_o(), .error_n_o, .error_oe_o(),
        .wr_strobe_o, .wr_kind_o, .wr_data_o, .rd_strobe_o(), .bus_phase_o()
    );
    cbt_host_model host (
        .clk_i, .ro_n_i(ready_out_n_o), .rdd_i(data_o), .wrd_i(wr_data_o),
        .ads_n_o(address_strobe_n_i), .rdy_n_o(ready_n_i), .en_o(status_enable_i),
        .s1_n_o(coproc_select_one_n_i), .s2_o(coproc_select_two_i), .cmd_n_o(command_select_n_i),
        .wnr_o(write_not_read_i), .env_o(env_restore_op_i), .wd_o(data_i)
    );
    // ---------
    // Scenarios
    // ---------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic t_kinds();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            read_data_i <= 32'h5A5A0000 | 32'(k);
            c0 = host.rdy_cnt;
            host.cyc(2'(k), 1'b0, 0, 32'hC0DE0000 | 32'(k), -1, rd);
            chk("data", (k[0] ? 32'hC0DE0000 : 32'h5A5A0000) | 32'(k), rd);
            chk("ready count", 32'h1, 32'(host.rdy_cnt - c0));
            chk("write strobe", 32'(k[0]), 32'(wr_strobe_o));
        end
    endtask
    task automatic t_waits();
        for (int i = 0; i < 2; i++) begin
            c0 = host.rdy_cnt;
            host.cyc(i ? 2'h2 : 2'h3, !i, 2 + i, 32'h0BAD0F00, -1, rd);
            chk("waited data", i ? 32'h5A5A0003 : 32'h0BAD0F00, rd);
            chk("ready count", 32'h1, 32'(host.rdy_cnt - c0));
        end
    endtask
    task automatic t_pipe();
        c0 = host.rdy_cnt;
        host.cyc(2'h3, 1'b0, 0, 32'hFACE0001, 2, rd);
        chk("first write", 32'hFACE0001, rd);
        host.cyc(2'h2, 1'b0, 0, 32'h0, 3, rd);
        chk("pipelined read", 32'h5A5A0003, rd);
        host.cyc(2'h3, 1'b0, 0, 32'h0, -1, rd);
        chk("pipelined write", 32'hFACE0001, rd);
        chk("ready count", 32'h3, 32'(host.rdy_cnt - c0));
    endtask
    task automatic t_desel();
        host.own = 1'b0;
        c0 = host.rdy_cnt;
        host.cyc(2'h3, 1'b0, 0, 32'h0, -1, rd);
        host.own = 1'b1;
        chk("foreign ready", 32'h0, 32'(host.rdy_cnt - c0));
        @(posedge clk_i);
        host.en_o <= 1'b0;
        @(negedge clk_i);
        chk("float", 32'h0, {30'h0, ready_out_oe_o, busy_oe_o});
        @(posedge clk_i);
        host.en_o <= 1'b1;
    endtask
    task automatic t_sync();
        @(posedge clk_i);
        exec_start_i <= 1'b1;
        @(posedge clk_i);
        exec_start_i <= 1'b0;
        operand_want_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk("busy and request", 32'h1, {30'h0, busy_n_o, operand_request_o});
        @(posedge clk_i);
        operand_want_i <= 1'b0;
        error_event_i <= 1'b1;
        @(posedge clk_i);
        error_event_i <= 1'b0;
        exec_done_i <= 1'b1;
        @(posedge clk_i);
        exec_done_i <= 1'b0;
        // Bounded, busy may be held back by the error gap
        for (int n = 0; n < 30 && busy_n_o !== 1'b1; n++) @(negedge clk_i);
        chk("busy end and error", 32'h2, {30'h0, busy_n_o, error_n_o});
        if (busy_n_o !== 1'b1) complete_run();
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        {rst_b_i, exec_start_i, exec_done_i, operand_want_i, error_event_i} = 5'h0;
        read_data_i = 32'h0;
        failures = 0;
        checked = 0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_kinds();
        t_waits();
        t_pipe();
        t_desel();
        t_sync();
        complete_run();
    end
endmodule // test_coproc_host_bus_tracker
`default_nettype wire
